/* File: hw/pmc_power_ctrl.sv */
// Power mode control: power control register, idle, power-down and
// emulation-mode entry, with strobe and port pin control.
// Assumes one 20 MHz clock, a synchronous active-high reset from the
// reset pin, and an AXI4-Lite master for the register.
//
// Function
// - Baud doubling only with timer 1 and modes 1-3.
// - Writing power-down bit starts power-down.
// - Writing sleep request bit starts idle.
// - Both bits written: power-down wins over idle.
// - Register resets with top and low bits zero.
// - Bits 3 and 2 are free user flags.
// - Setting write is last; power-down follows immediately.
// - Power-down stops the oscillator.
// - Power-down keeps RAM and register contents.
// - Power-down: ports keep driving latch values.
// - Power-down holds both strobes low.
// - Only hardware reset ends power-down.
// - Ending reset reloads registers, keeps RAM.
// - Ending reset frees the oscillator.
// - Strobe low through reset release enters emulation.
// - Emulation floats port 0, weakly pulls others.
// - Oscillator keeps running in emulation.
// - Only a normal reset leaves emulation.
// - Idle gates CPU clock, peripherals keep clock.
// - Enabled interrupt in idle clears sleep bit.
// - Reset pin clears sleep bit asynchronously.
`timescale 1ns/10ps
`default_nettype none

module pmc_power_ctrl (
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        reset,
   // AXI4-Lite write address and data.
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read.
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Core side status.
   input  wire logic        irq_pending,
   input  wire logic        timer1_baud_sel,
   input  wire logic [1:0]  serial_mode,
   input  wire logic        core_ale,
   input  wire logic        core_program_store_strobe,
   // Clock control.
   output logic             osc_enable,
   output logic             cpu_clk_en,
   output logic             periph_clk_en,
   output logic             baud_double,
   // Address latch strobe pin.
   input  wire logic        ale_in,
   output logic             ale_out,
   output logic             ale_oe,
   // Program store strobe pin.
   input  wire logic        program_store_strobe_in,
   output logic             program_store_strobe_out,
   output logic             program_store_strobe_oe,
   // Pin mode control.
   output logic             strobe_weak_pull,
   output logic             port0_float,
   output logic             port_weak_pull,
   output logic             port_hold
);

   // ==========================================================
   // State
   // ==========================================================
   pmc_pkg::pmc_mode_t mode_q;      // Present mode.
   pmc_pkg::pmc_mode_t mode_d;      // Next mode.
   logic        baud_dbl_q;         // Baud doubling bit.
   logic [1:0]  flags_q;            // User flags 1 and 0.
   logic        ale_s1_q;           // Strobe pin sync, stage one.
   logic        ale_s2_q;           // Strobe pin sync, stage two.
   logic        pss_s1_q;           // Store strobe sync, stage one.
   logic        pss_s2_q;           // Store strobe sync, stage two.
   logic        strap_q;            // Emulation request seen in reset.
   logic        reset_dly_q;        // Reset one cycle ago.
   logic        aw_held_q;          // Write address taken.
   logic [31:0] awaddr_q;           // Taken write address.
   logic        w_held_q;           // Write data taken.
   logic [31:0] wdata_q;            // Taken write data.
   logic        wlane0_q;           // Low byte lane enabled.
   logic        bvalid_q;           // Write answer pending.
   logic [1:0]  bresp_q;            // Write answer code.
   logic        rvalid_q;           // Read answer pending.
   logic [1:0]  rresp_q;            // Read answer code.
   logic [31:0] rdata_q;            // Read data.
   logic        ale_out_q;          // Strobe pin level.
   logic        ale_oe_q;           // Strobe pin drive.
   logic        pss_out_q;          // Store strobe level.
   logic        pss_oe_q;           // Store strobe drive.
   logic        weak_q;             // Strobe weak pull.
   logic        p0_float_q;         // Port 0 float.
   logic        port_pull_q;        // Other ports weak pull.
   logic        hold_q;             // Ports hold latches.
   logic        wr_commit;          // Write performed this cycle.
   logic        wr_ctrl;            // Commit hits power control.
   logic        sleep_bit;          // Sleep bit as software sees it.
   logic [7:0]  power_control;      // Register image.
   logic [7:0]  mode_status;        // Status image.

   // Address match used by both read and write decoding.
   function automatic logic addr_is(input logic [31:0] a,
                                    input logic [31:0] r);
      addr_is = (a[7:2] == r[7:2]) && (a[31:8] == 24'h00_0000);
   endfunction : addr_is

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   // Strobe pins come from the tester, so each passes two stages.
   always_ff @(posedge core_clk) begin
      ale_s1_q <= ale_in;
      ale_s2_q <= ale_s1_q;
      pss_s1_q <= program_store_strobe_in;
      pss_s2_q <= pss_s1_q;
   end

   // Emulation request is the strobe pattern on the last cycle of
   // reset; it is caught by the clock, never by the reset itself.
   always_ff @(posedge core_clk) begin
      reset_dly_q <= reset;
      if (reset) begin
         strap_q <= !ale_s2_q && pss_s2_q;
      end
   end

   // ==========================================================
   // AXI4-Lite write channel
   // ==========================================================
   // Address and data are taken in either order; the answer follows
   // both. One write at a time, so ready drops while one is held.
   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready  = !w_held_q && !bvalid_q;
   assign wr_commit     = aw_held_q && w_held_q && !bvalid_q;
   assign wr_ctrl       = wr_commit && wlane0_q
                          && addr_is(awaddr_q, pmc_pkg::ADDR_POWER_CONTROL);

   // Holding registers for address and data.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         awaddr_q  <= 32'h0000_0000;
         wdata_q   <= 32'h0000_0000;
         wlane0_q  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end else if (wr_commit) begin
            aw_held_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wlane0_q <= s_axi_wstrb[0];
         end else if (wr_commit) begin
            w_held_q <= 1'b0;
         end
      end
   end

   // Write answer: status register is read-only, other offsets error.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         bvalid_q <= 1'b0;
         bresp_q  <= pmc_pkg::RESP_OKAY;
      end else if (wr_commit) begin
         bvalid_q <= 1'b1;
         if (addr_is(awaddr_q, pmc_pkg::ADDR_POWER_CONTROL)) begin
            bresp_q <= pmc_pkg::RESP_OKAY;
         end else if (addr_is(awaddr_q, pmc_pkg::ADDR_MODE_STATUS)) begin
            bresp_q <= pmc_pkg::RESP_OKAY;
         end else begin
            bresp_q <= pmc_pkg::RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   // ==========================================================
   // Power control register
   // ==========================================================
   // Baud bit and flags. A frozen device keeps them, so writes in
   // power-down or emulation are dropped.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         baud_dbl_q <= pmc_pkg::RESET_POWER_CONTROL[pmc_pkg::BIT_BAUD_DOUBLE];
         flags_q    <= pmc_pkg::RESET_POWER_CONTROL[pmc_pkg::BIT_USER_FLAG_1
                                                    :pmc_pkg::BIT_USER_FLAG_0];
      end else if (wr_ctrl && mode_q != pmc_pkg::MODE_POWER_DOWN
                   && mode_q != pmc_pkg::MODE_EMULATION) begin
         baud_dbl_q <= wdata_q[pmc_pkg::BIT_BAUD_DOUBLE];
         flags_q    <= {wdata_q[pmc_pkg::BIT_USER_FLAG_1],
                        wdata_q[pmc_pkg::BIT_USER_FLAG_0]};
      end
   end

   // Sleep bit drops with the reset pin, no clock edge needed.
   assign sleep_bit = (mode_q == pmc_pkg::MODE_IDLE) && !reset;

   // Reserved bits 6 to 4 are not stored and read as zero.
   assign power_control = {baud_dbl_q, 3'b000, flags_q,
                           mode_q == pmc_pkg::MODE_POWER_DOWN,
                           sleep_bit};
   assign mode_status = {5'b00000,
                         mode_q == pmc_pkg::MODE_EMULATION,
                         mode_q == pmc_pkg::MODE_POWER_DOWN,
                         sleep_bit};

   // ==========================================================
   // Mode sequencer
   // ==========================================================
   // In idle an interrupt clears the sleep bit in the same cycle a
   // write might set it; the clear wins so a wake is never missed.
   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         pmc_pkg::MODE_RUN: begin
            if (wr_ctrl && wdata_q[pmc_pkg::BIT_POWER_DOWN]) begin
               mode_d = pmc_pkg::MODE_POWER_DOWN;
            end else if (wr_ctrl && wdata_q[pmc_pkg::BIT_SLEEP_REQ]
                         && !irq_pending) begin
               mode_d = pmc_pkg::MODE_IDLE;
            end
         end
         pmc_pkg::MODE_IDLE: begin
            if (wr_ctrl && wdata_q[pmc_pkg::BIT_POWER_DOWN]) begin
               mode_d = pmc_pkg::MODE_POWER_DOWN;
            end else if (irq_pending) begin
               mode_d = pmc_pkg::MODE_RUN;
            end else if (wr_ctrl && !wdata_q[pmc_pkg::BIT_SLEEP_REQ]) begin
               mode_d = pmc_pkg::MODE_RUN;
            end
         end
         // Neither writes nor interrupts leave these modes.
         pmc_pkg::MODE_POWER_DOWN: mode_d = pmc_pkg::MODE_POWER_DOWN;
         pmc_pkg::MODE_EMULATION:  mode_d = pmc_pkg::MODE_EMULATION;
         default:                  mode_d = pmc_pkg::MODE_RUN;
      endcase
      // Reset ends every mode; on its release the strap decides.
      if (reset) begin
         mode_d = pmc_pkg::MODE_RUN;
      end else if (reset_dly_q && strap_q && !ale_s2_q) begin
         mode_d = pmc_pkg::MODE_EMULATION;
      end
   end

   // Mode register.
   always_ff @(posedge core_clk) begin
      mode_q <= mode_d;
   end

   // ==========================================================
   // Clock control
   // ==========================================================
   // Reset releases the oscillator even from power-down.
   assign osc_enable    = reset || mode_q != pmc_pkg::MODE_POWER_DOWN;
   assign periph_clk_en = osc_enable;
   assign cpu_clk_en    = reset || mode_q == pmc_pkg::MODE_RUN;
   assign baud_double   = baud_dbl_q && timer1_baud_sel
                          && serial_mode != 2'b00;

   // ==========================================================
   // Pin control
   // ==========================================================
   // Pin controls follow the next mode so they change with it.
   // During reset the strobes float so a tester can pull them low.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ale_out_q <= 1'b1;
         ale_oe_q  <= 1'b0;
         pss_out_q <= 1'b1;
         pss_oe_q  <= 1'b0;
         weak_q    <= 1'b1;
      end else begin
         case (mode_d)
            pmc_pkg::MODE_RUN: begin
               ale_out_q <= core_ale;
               ale_oe_q  <= 1'b1;
               pss_out_q <= core_program_store_strobe;
               pss_oe_q  <= 1'b1;
               weak_q    <= 1'b0;
            end
            pmc_pkg::MODE_IDLE: begin
               ale_out_q <= 1'b1;
               ale_oe_q  <= 1'b1;
               pss_out_q <= 1'b1;
               pss_oe_q  <= 1'b1;
               weak_q    <= 1'b0;
            end
            pmc_pkg::MODE_POWER_DOWN: begin
               ale_out_q <= 1'b0;
               ale_oe_q  <= 1'b1;
               pss_out_q <= 1'b0;
               pss_oe_q  <= 1'b1;
               weak_q    <= 1'b0;
            end
            default: begin
               ale_out_q <= 1'b1;
               ale_oe_q  <= 1'b0;
               pss_out_q <= 1'b1;
               pss_oe_q  <= 1'b0;
               weak_q    <= 1'b1;
            end
         endcase
      end
   end

   // Port pin modes.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         p0_float_q  <= 1'b0;
         port_pull_q <= 1'b0;
         hold_q      <= 1'b0;
      end else begin
         p0_float_q  <= mode_d == pmc_pkg::MODE_EMULATION;
         port_pull_q <= mode_d == pmc_pkg::MODE_EMULATION;
         hold_q      <= mode_d == pmc_pkg::MODE_POWER_DOWN;
      end
   end

   assign ale_out                  = ale_out_q;
   assign ale_oe                   = ale_oe_q;
   assign program_store_strobe_out = pss_out_q;
   assign program_store_strobe_oe  = pss_oe_q;
   assign strobe_weak_pull         = weak_q;
   assign port0_float              = p0_float_q;
   assign port_weak_pull           = port_pull_q;
   assign port_hold                = hold_q;

   // ==========================================================
   // AXI4-Lite read channel
   // ==========================================================
   assign s_axi_arready = !rvalid_q;

   // Read answer one cycle after the address is taken.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rvalid_q <= 1'b0;
         rresp_q  <= pmc_pkg::RESP_OKAY;
         rdata_q  <= 32'h0000_0000;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         if (addr_is(s_axi_araddr, pmc_pkg::ADDR_POWER_CONTROL)) begin
            rresp_q <= pmc_pkg::RESP_OKAY;
            rdata_q <= {24'h00_0000, power_control};
         end else if (addr_is(s_axi_araddr, pmc_pkg::ADDR_MODE_STATUS)) begin
            rresp_q <= pmc_pkg::RESP_OKAY;
            rdata_q <= {24'h00_0000, mode_status};
         end else begin
            rresp_q <= pmc_pkg::RESP_SLVERR;
            rdata_q <= 32'h0000_0000;
         end
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp  = rresp_q;
   assign s_axi_rdata  = rdata_q;

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking chk_cb @(posedge core_clk); endclocking
   default disable iff (reset);

   chk_baud_gate: assert property (
      baud_double |-> baud_dbl_q && timer1_baud_sel && serial_mode != 2'b00)
      else $error("baud doubling outside its conditions");

   chk_pd_entry: assert property (
      wr_ctrl && wdata_q[1] && mode_q == pmc_pkg::MODE_RUN
      |=> mode_q == pmc_pkg::MODE_POWER_DOWN && !cpu_clk_en ##1 port_hold)
      else $error("power-down not entered after write");

   chk_idle_entry: assert property (
      wr_ctrl && wdata_q[1:0] == 2'b01 && !irq_pending
      && mode_q == pmc_pkg::MODE_RUN
      |=> sleep_bit && !cpu_clk_en && periph_clk_en)
      else $error("idle not entered after write");

   chk_pd_wins: assert property (
      wr_ctrl && wdata_q[1:0] == 2'b11 |=> !sleep_bit)
      else $error("idle taken over power-down");

   chk_pd_frozen: assert property (
      mode_q == pmc_pkg::MODE_POWER_DOWN && !reset
      |=> mode_q == pmc_pkg::MODE_POWER_DOWN && !osc_enable
      && $stable(power_control))
      else $error("power-down state disturbed");

   chk_pd_strobes: assert property (
      $past(mode_q) == pmc_pkg::MODE_POWER_DOWN
      && mode_q == pmc_pkg::MODE_POWER_DOWN
      |-> !ale_out && ale_oe && !program_store_strobe_out && port_hold)
      else $error("strobes not held low in power-down");

   chk_reset_clears: assert property (disable iff (1'b0)
      reset |-> osc_enable && !sleep_bit ##1 power_control == 8'h00)
      else $error("reset did not reload register");

   chk_emul_pins: assert property (
      $past(mode_q) == pmc_pkg::MODE_EMULATION
      |-> !ale_oe && !program_store_strobe_oe && strobe_weak_pull
      && port0_float && port_weak_pull && osc_enable)
      else $error("emulation pin state wrong");

   chk_emul_entry: assert property (disable iff (1'b0)
      reset ##1 !reset && strap_q && !ale_s2_q
      |=> mode_q == pmc_pkg::MODE_EMULATION)
      else $error("emulation strap not honoured");

   chk_idle_wake: assert property (
      mode_q == pmc_pkg::MODE_IDLE && irq_pending && !wdata_q[1]
      |=> !sleep_bit)
      else $error("interrupt did not end idle");

endmodule : pmc_power_ctrl

`default_nettype wire

/* File: hw/pmc_pkg.sv */
// Package for the power mode control block: register map, fields, modes.
// Assumes an AXI4-Lite master with 32-bit data reaches the registers.
package pmc_pkg;

   // ==========================================================
   // Register byte offsets
   // ==========================================================
   localparam logic [31:0] ADDR_POWER_CONTROL = 32'h0000_0000;
   localparam logic [31:0] ADDR_MODE_STATUS   = 32'h0000_0004;

   // ==========================================================
   // Power control fields
   // ==========================================================
   localparam int BIT_BAUD_DOUBLE = 7;  // Serial baud doubling.
   localparam int BIT_USER_FLAG_1 = 3;  // Software flag.
   localparam int BIT_USER_FLAG_0 = 2;  // Software flag.
   localparam int BIT_POWER_DOWN  = 1;  // Power-down request.
   localparam int BIT_SLEEP_REQ   = 0;  // Idle request.

   // Reset value of the power control register.
   localparam logic [7:0] RESET_POWER_CONTROL = 8'h00;

   // ==========================================================
   // Mode status fields
   // ==========================================================
   localparam int ST_SLEEP      = 0;
   localparam int ST_POWER_DOWN = 1;
   localparam int ST_EMULATION  = 2;

   // ==========================================================
   // Bus answers
   // ==========================================================
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Operating modes of the device.
   typedef enum logic [1:0] {
      MODE_RUN        = 2'b00,
      MODE_IDLE       = 2'b01,
      MODE_POWER_DOWN = 2'b10,
      MODE_EMULATION  = 2'b11
   } pmc_mode_t;

endpackage : pmc_pkg

/* File: verif/pmc_pin_model.sv */
// Pin-side partner: the strobe pins as seen by an emulator or tester.
// Assumes the bench raises emu_hold to pull the latch strobe low.
`timescale 1ns/10ps
`default_nettype none
module pmc_pin_model (
   // Design strobe drivers.
   input  wire logic ale_out,
   input  wire logic ale_oe,
   input  wire logic pss_out,
   input  wire logic pss_oe,
   // Tester request to hold the latch strobe low.
   input  wire logic emu_hold,
   // Resolved pin levels.
   output logic      ale_pin,
   output logic      pss_pin
);
   // ==========================================================
   // Pin resolution
   // ==========================================================
   // A released pin shows its pull-up level unless emu_hold pulls the latch strobe low, never the last driven value.
   always_comb begin
      ale_pin = ale_oe ? ale_out : !emu_hold;
      pss_pin = pss_oe ? pss_out : 1'b1;
   end
endmodule : pmc_pin_model
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the power mode control block.
// Assumes the AXI4-Lite register map of the package and one 20 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
   $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module tb_top;
   // One table row: written value, core status, expected readback and doubling.
   // Rows never set the reserved bits 6 to 4, as software must not.
   typedef struct packed {logic [7:0] w; logic sel; logic [1:0] md; logic [7:0] r; logic bd;} pmc_row_t;
   logic        core_clk = 1'b0, reset = 1'b1, emu_hold = 1'b0;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rd;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, irq = 0, t1sel = 0;
   logic [1:0]  smode = '0, bresp, rresp, resp;
   logic        awready, wready, bvalid, arready, rvalid, osc_en, cpu_en, per_en, baud;
   logic        ale_out, ale_oe, pss_out, pss_oe, sw_pull, p0_float, p_pull, p_hold, ale_pin, pss_pin;
   int          fail_count = 0, checks_done = 0;
   pmc_row_t    rows [6] = '{'{8'h80, 1'b1, 2'h1, 8'h80, 1'b1}, '{8'h80, 1'b0, 2'h1, 8'h80, 1'b0},
      '{8'h80, 1'b1, 2'h0, 8'h80, 1'b0}, '{8'h8c, 1'b1, 2'h3, 8'h8c, 1'b1},
      '{8'h08, 1'b1, 2'h2, 8'h08, 1'b0}, '{8'h0c, 1'b1, 2'h2, 8'h0c, 1'b0}};
   // 50 ns period.
   always #25 core_clk = ~core_clk;
   pmc_power_ctrl uut (.core_clk(core_clk), .reset(reset), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .irq_pending(irq), .timer1_baud_sel(t1sel), .serial_mode(smode),
      .core_ale(1'b1), .core_program_store_strobe(1'b1), .osc_enable(osc_en),
      .cpu_clk_en(cpu_en), .periph_clk_en(per_en), .baud_double(baud), .ale_in(ale_pin),
      .ale_out(ale_out), .ale_oe(ale_oe), .program_store_strobe_in(pss_pin),
      .program_store_strobe_out(pss_out), .program_store_strobe_oe(pss_oe),
      .strobe_weak_pull(sw_pull), .port0_float(p0_float), .port_weak_pull(p_pull),
      .port_hold(p_hold));
   pmc_pin_model pins (.ale_out(ale_out), .ale_oe(ale_oe), .pss_out(pss_out), .pss_oe(pss_oe),
      .emu_hold(emu_hold), .ale_pin(ale_pin), .pss_pin(pss_pin));
   // ==========================================================
   // Bus tasks
   // ==========================================================
   // Ready and valid are looked at on the rising edge that takes the item, so
   // every request stands until that edge and the answer is taken there too.
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bit aw_ok, w_ok;
      aw_ok = 0;
      w_ok = 0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge core_clk);
         aw_ok |= awvalid & awready;
         w_ok |= wvalid & wready;
         if (aw_ok) awvalid <= 1'b0;
         if (w_ok) wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1) @(posedge core_clk);
      resp = bresp;
      bready <= 1'b0;
   endtask : wr
   // Read one word into rd and resp.
   task automatic rd_reg(input logic [31:0] a);
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge core_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge core_clk); while (rvalid !== 1'b1);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : rd_reg
   // Reset for 4 cycles; the tester may hold the strobe low past release.
   task automatic do_reset(input bit emu);
      @(posedge core_clk);
      reset <= 1'b1;
      emu_hold <= emu;
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      repeat (3) @(posedge core_clk);
      emu_hold <= 1'b0;
   endtask : do_reset
   // Single exit point of the run.
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   // ==========================================================
   // Watchdog and main sequence
   // ==========================================================
   // The sequence needs well under 2000 cycles; 20000 leaves margin.
   initial begin
      #(20000 * 50);
      fail_count++;
      $display("ERROR %0t: timeout", $time);
      end_sim();
   end
   initial begin
      do_reset(1'b0);
      rd_reg(pmc_pkg::ADDR_POWER_CONTROL);
      `CHK(rd, 32'h0)
      foreach (rows[i]) begin
         t1sel <= rows[i].sel;
         smode <= rows[i].md;
         wr(pmc_pkg::ADDR_POWER_CONTROL, {24'h0, rows[i].w});
         rd_reg(pmc_pkg::ADDR_POWER_CONTROL);
         `CHK(rd, {24'h0, rows[i].r})
         `CHK(baud, rows[i].bd)
      end
      $display("table done");
      wr(pmc_pkg::ADDR_POWER_CONTROL, 32'h01);
      `CHK({cpu_en, per_en}, 2'b01)
      irq <= 1'b1;
      repeat (2) @(posedge core_clk);
      `CHK(cpu_en, 1'b1)
      irq <= 1'b0;
      rd_reg(pmc_pkg::ADDR_POWER_CONTROL);
      `CHK(rd[0], 1'b0)
      $display("idle done");
      wr(pmc_pkg::ADDR_POWER_CONTROL, 32'h03);
      `CHK({osc_en, cpu_en}, 2'b00)
      `CHK({ale_pin, pss_pin, p_hold}, 3'b001)
      wr(pmc_pkg::ADDR_POWER_CONTROL, 32'h00);
      `CHK(resp, pmc_pkg::RESP_OKAY)
      irq <= 1'b1;
      repeat (2) @(posedge core_clk);
      `CHK(osc_en, 1'b0)
      irq <= 1'b0;
      rd_reg(pmc_pkg::ADDR_POWER_CONTROL);
      `CHK(rd, 32'h0000_0002)
      rd_reg(pmc_pkg::ADDR_MODE_STATUS);
      `CHK(rd[pmc_pkg::ST_POWER_DOWN], 1'b1)
      do_reset(1'b0);
      `CHK(osc_en, 1'b1)
      rd_reg(pmc_pkg::ADDR_POWER_CONTROL);
      `CHK(rd, 32'h0)
      $display("power-down done");
      rd_reg(32'h0000_0010);
      `CHK({resp, rd}, {pmc_pkg::RESP_SLVERR, 32'h0})
      do_reset(1'b1);
      `CHK({p0_float, p_pull, sw_pull}, 3'b111)
      `CHK(osc_en, 1'b1)
      do_reset(1'b0);
      `CHK(p0_float, 1'b0)
      $display("emulation done");
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
